// File: lsa_consts.vh
`ifndef LSA_CONSTS_VH
`define LSA_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LSA_REG_CTRL 8'h00
`define LSA_REG_WIDTH 8'h04
`define LSA_REG_OFFSET 8'h08
`define LSA_REG_PERIOD 8'h0C
`define LSA_REG_MASK 8'h10
`define LSA_REG_CMD 8'h14
`define LSA_REG_STATUS 8'h18
`define LSA_REG_HEIGHT 8'h1C

// ----------------------------------------
// Control fields
// ----------------------------------------
`define LSA_CTRL_BIN 0
`define LSA_CTRL_AVG 1
`define LSA_CTRL_DEPTH_LO 2
`define LSA_CTRL_TRIG_EN 4
`define LSA_CTRL_FUNC_LO 5
`define LSA_CMD_BEGIN 0
`define LSA_CMD_HALT 1

// ----------------------------------------
// Encodings
// ----------------------------------------
`define LSA_DEPTH_8 2'h0
`define LSA_DEPTH_10 2'h1
`define LSA_DEPTH_12 2'h2
`define LSA_FUNC_START 2'h0
`define LSA_FUNC_FINISH 2'h1
`define LSA_FUNC_LINE 2'h2

// ----------------------------------------
// Geometry and reset values
// ----------------------------------------
`define LSA_LINE_LEN 13'h0800
`define LSA_LINE_LEN_BIN 13'h0400
`define LSA_WIDTH_MIN 12'h080
`define LSA_WIDTH_MIN_BIN 12'h040
`define LSA_HEIGHT 32'h00000001
`define LSA_WIDTH_RST 12'h800
`define LSA_OFFSET_RST 12'h000
`define LSA_MASK_RST 16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define LSA_CLK_HZ 250000000
`define LSA_RATE_MIN_HZ 66
`define LSA_RATE_MAX_MONO_HZ 172000
`define LSA_RATE_MAX_COLOR_HZ 44000
`define LSA_PERIOD_MAX_CYC (`LSA_CLK_HZ / `LSA_RATE_MIN_HZ)
`define LSA_PERIOD_MIN_MONO_CYC ((`LSA_CLK_HZ + `LSA_RATE_MAX_MONO_HZ - 1) / `LSA_RATE_MAX_MONO_HZ)
`define LSA_PERIOD_MIN_COLOR_CYC ((`LSA_CLK_HZ + `LSA_RATE_MAX_COLOR_HZ - 1) / `LSA_RATE_MAX_COLOR_HZ)

`endif

// File: lsa_line_scan_acq.v
// Overview of operation
// - Image height is always one line.
// - Unbinned width 128 to 2048-offset, step 8.
// - Binned width 64 to 1024-offset, step 8.
// - Offset 0 to line length minus width.
// - Readout starts at zero-based offset pixel.
// - Binning merges adjacent horizontal pixel pairs.
// - Binning sums or averages each pair.
// - Output depth 8, 10 or 12 bits.
// - Begin command starts, halt command stops.
// - Start-function and per-line triggered output need begin then trigger.
// - Untriggered lines paced internally, min 66 Hz.
// - Internally paced line rate capped at sensor limit.
// - Start-function trigger starts acquisition.
// - Finish-function trigger stops acquisition.
// - Per-line function acquires one line per trigger.
// - Output masked for programmed lines after start.
// - Masking applies to untriggered and start-function runs.
// - Mask forced to zero for finish/per-line.
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`include "lsa_consts.vh"

// ----------------------------------------
// Stream FIFO
// ----------------------------------------
module lsa_fifo #(
  parameter W = 37,
  parameter DEPTH = 16,
  parameter AW = 4,
  parameter LW = 5
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire clk_en_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o,
  output wire [LW-1:0] level_o
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [LW-1:0] level_r;
  wire push;
  wire pop;

  assign in_ready_o = (level_r != DEPTH[LW-1:0]);
  assign out_valid_o = (level_r != {LW{1'b0}});
  assign out_data_o = mem[rd_ptr_r];
  assign level_o = level_r;
  assign push = in_valid_i && in_ready_o && clk_en_i;
  assign pop = out_valid_o && out_ready_i && clk_en_i;

  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data_i;
    end
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      level_r <= {LW{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        level_r <= level_r + 1'b1;
      end else if (pop && !push) begin
        level_r <= level_r - 1'b1;
      end
    end
  end
endmodule

// ----------------------------------------
// Acquisition control and readout
// ----------------------------------------
module lsa_line_scan_acq #(
  parameter COLOR = 0,
  parameter PIX_W = 12,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4,
  parameter FIFO_LW = 5,
  parameter [31:0] MIN_PERIOD_CYC = COLOR ? `LSA_PERIOD_MIN_COLOR_CYC : `LSA_PERIOD_MIN_MONO_CYC,
  parameter [31:0] MAX_PERIOD_CYC = `LSA_PERIOD_MAX_CYC
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire clk_en_i,
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  input wire ext_trigger_i,
  output reg line_req_o,
  input wire px_valid_i,
  output wire px_ready_o,
  input wire [3*PIX_W-1:0] px_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [3*PIX_W-1:0] out_data_o,
  output wire out_last_o
);
  localparam ST_IDLE = 3'b001;
  localparam ST_ARMED = 3'b010;
  localparam ST_RUN = 3'b100;

  reg bin_r;
  reg avg_r;
  reg [1:0] depth_r;
  reg trig_en_r;
  reg [1:0] func_r;
  reg [11:0] width_r;
  reg [11:0] offset_r;
  reg [31:0] period_r;
  reg [15:0] mask_lines_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [15:0] mask_cnt_r;
  reg [31:0] pace_cnt_r;
  reg pend_r;
  reg busy_r;
  reg keep_r;
  reg [11:0] pix_idx_r;
  reg [3*PIX_W-1:0] held_r;
  reg trig_d_r;

  wire trig_edge = ext_trigger_i && !trig_d_r;
  wire begin_cmd = reg_wr_i && reg_addr_i == `LSA_REG_CMD && reg_wdata_i[`LSA_CMD_BEGIN];
  wire halt_cmd = reg_wr_i && reg_addr_i == `LSA_REG_CMD && reg_wdata_i[`LSA_CMD_HALT];
  wire wr_ctrl = reg_wr_i && reg_addr_i == `LSA_REG_CTRL;
  wire wr_width = reg_wr_i && reg_addr_i == `LSA_REG_WIDTH;
  wire wr_offset = reg_wr_i && reg_addr_i == `LSA_REG_OFFSET;
  wire wr_period = reg_wr_i && reg_addr_i == `LSA_REG_PERIOD;
  wire wr_mask = reg_wr_i && reg_addr_i == `LSA_REG_MASK;
  wire line_mode = trig_en_r && func_r == `LSA_FUNC_LINE;

  // ----------------------------------------
  // Geometry checks
  // ----------------------------------------
  function geom_ok;
    input bin;
    input [11:0] w;
    input [11:0] o;
    reg [12:0] len;
    reg [11:0] wmin;
    begin
      len = bin ? `LSA_LINE_LEN_BIN : `LSA_LINE_LEN;
      wmin = bin ? `LSA_WIDTH_MIN_BIN : `LSA_WIDTH_MIN;
      geom_ok = (w[2:0] == 3'h0) && (o[2:0] == 3'h0) && (w >= wmin) &&
        ({1'b0, w} + {1'b0, o} <= len);
    end
  endfunction

  wire [11:0] new_val = reg_wdata_i[11:0];
  wire new_bin = reg_wdata_i[`LSA_CTRL_BIN];
  wire [1:0] new_depth = reg_wdata_i[`LSA_CTRL_DEPTH_LO+1:`LSA_CTRL_DEPTH_LO];
  wire [1:0] new_func = reg_wdata_i[`LSA_CTRL_FUNC_LO+1:`LSA_CTRL_FUNC_LO];

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bin_r <= 1'b0;
      avg_r <= 1'b0;
      depth_r <= `LSA_DEPTH_8;
      trig_en_r <= 1'b0;
      func_r <= `LSA_FUNC_START;
      width_r <= `LSA_WIDTH_RST;
      offset_r <= `LSA_OFFSET_RST;
      period_r <= MIN_PERIOD_CYC;
      mask_lines_r <= `LSA_MASK_RST;
    end else if (clk_en_i) begin
      if (wr_ctrl) begin
        // Binning only changes if the current region fits the new line length
        if (geom_ok(new_bin, width_r, offset_r)) begin
          bin_r <= new_bin;
        end
        avg_r <= reg_wdata_i[`LSA_CTRL_AVG];
        if (new_depth != 2'h3) begin
          depth_r <= new_depth;
        end
        trig_en_r <= reg_wdata_i[`LSA_CTRL_TRIG_EN];
        if (new_func != 2'h3) begin
          func_r <= new_func;
        end
      end
      if (wr_width && geom_ok(bin_r, new_val, offset_r)) begin
        width_r <= new_val;
      end
      if (wr_offset && geom_ok(bin_r, width_r, new_val)) begin
        offset_r <= new_val;
      end
      if (wr_period && reg_wdata_i >= MIN_PERIOD_CYC && reg_wdata_i <= MAX_PERIOD_CYC) begin
        period_r <= reg_wdata_i;
      end
      if (wr_mask) begin
        mask_lines_r <= reg_wdata_i[15:0];
      end
    end
  end

  // ----------------------------------------
  // Acquisition state
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (begin_cmd) begin
          state_nxt = (trig_en_r && func_r == `LSA_FUNC_START) ? ST_ARMED : ST_RUN;
        end
      end
      ST_ARMED: begin
        if (halt_cmd) begin
          state_nxt = ST_IDLE;
        end else if (trig_edge) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (halt_cmd) begin
          state_nxt = ST_IDLE;
        end else if (trig_en_r && func_r == `LSA_FUNC_FINISH && trig_edge) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  wire running = state_r == ST_RUN;
  wire enter_run = state_nxt == ST_RUN && !running;
  wire pace_tick = running && !line_mode && pace_cnt_r == 32'h00000000;
  wire line_tick = running && line_mode && trig_edge;
  wire launch = running && pend_r && !busy_r;

  // ----------------------------------------
  // Pixel path
  // ----------------------------------------
  wire fifo_in_ready;
  wire [FIFO_LW-1:0] fifo_level;
  wire px_take = px_valid_i && px_ready_o && busy_r;
  wire [11:0] out_idx = bin_r ? {1'b0, pix_idx_r[11:1]} : pix_idx_r;
  wire [12:0] win_end = {1'b0, offset_r} + {1'b0, width_r};
  wire in_win = out_idx >= offset_r && {1'b0, out_idx} < win_end;
  wire emit_slot = !bin_r || pix_idx_r[0];
  wire push = px_take && keep_r && emit_slot && in_win;
  wire is_last = {1'b0, out_idx} == win_end - 13'h0001;
  wire [3*PIX_W-1:0] shaped;

  // Sensor stalls while the FIFO is full, so no pixel is ever dropped
  assign px_ready_o = fifo_in_ready && busy_r;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_comp
      wire [PIX_W-1:0] a = held_r[gi*PIX_W +: PIX_W];
      wire [PIX_W-1:0] b = px_data_i[gi*PIX_W +: PIX_W];
      wire [PIX_W:0] sum = {1'b0, a} + {1'b0, b};
      wire [PIX_W-1:0] sat = sum[PIX_W] ? {PIX_W{1'b1}} : sum[PIX_W-1:0];
      wire [PIX_W-1:0] pair = avg_r ? sum[PIX_W:1] : sat;
      wire [PIX_W-1:0] raw = bin_r ? pair : b;
      wire [PIX_W-1:0] dep = (depth_r == `LSA_DEPTH_8) ? (raw >> 4) :
        (depth_r == `LSA_DEPTH_10) ? (raw >> 2) : raw;
      // Mono parts carry a single component in the low lane
      assign shaped[gi*PIX_W +: PIX_W] = (COLOR != 0 || gi == 0) ? dep : {PIX_W{1'b0}};
    end
  endgenerate

  lsa_fifo #(
    .W(3*PIX_W+1),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW),
    .LW(FIFO_LW)
  ) u_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i({is_last, shaped}),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o({out_last_o, out_data_o}),
    .level_o(fifo_level)
  );

  // ----------------------------------------
  // Line sequencing
  // ----------------------------------------
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= ST_IDLE;
      mask_cnt_r <= 16'h0000;
      pace_cnt_r <= 32'h00000000;
      pend_r <= 1'b0;
      busy_r <= 1'b0;
      keep_r <= 1'b0;
      pix_idx_r <= 12'h000;
      held_r <= {3*PIX_W{1'b0}};
      trig_d_r <= 1'b0;
      line_req_o <= 1'b0;
    end else if (clk_en_i) begin
      state_r <= state_nxt;
      trig_d_r <= ext_trigger_i;
      line_req_o <= launch;
      if (enter_run) begin
        // Only untriggered runs and the start function may delay output
        mask_cnt_r <= (trig_en_r && func_r != `LSA_FUNC_START) ? 16'h0000 : mask_lines_r;
      end else if (launch && mask_cnt_r != 16'h0000) begin
        mask_cnt_r <= mask_cnt_r - 16'h0001;
      end
      if (!running || pace_tick) begin
        pace_cnt_r <= period_r - 32'h00000001;
      end else begin
        pace_cnt_r <= pace_cnt_r - 32'h00000001;
      end
      // A new tick wins over the launch that clears the pending flag
      if (pace_tick || line_tick) begin
        pend_r <= 1'b1;
      end else if (launch || !running) begin
        pend_r <= 1'b0;
      end
      if (launch) begin
        busy_r <= 1'b1;
        keep_r <= mask_cnt_r == 16'h0000;
        pix_idx_r <= 12'h000;
      end else if (px_take) begin
        if (!pix_idx_r[0]) begin
          held_r <= px_data_i;
        end
        // Sensor always delivers the full line; the window picks the region
        // A line is 2048 sensor pixels, index 0 to 2047
        if (pix_idx_r == 12'h7FF) begin
          busy_r <= 1'b0;
        end
        pix_idx_r <= pix_idx_r + 12'h001;
      end
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (clk_en_i) begin
      reg_rdata_o <= 32'h00000000;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `LSA_REG_CTRL: begin
            reg_rdata_o <= {25'h0000000, func_r, trig_en_r, depth_r, avg_r, bin_r};
          end
          `LSA_REG_WIDTH: begin
            reg_rdata_o <= {20'h00000, width_r};
          end
          `LSA_REG_OFFSET: begin
            reg_rdata_o <= {20'h00000, offset_r};
          end
          `LSA_REG_PERIOD: begin
            reg_rdata_o <= period_r;
          end
          `LSA_REG_MASK: begin
            reg_rdata_o <= {16'h0000, mask_lines_r};
          end
          `LSA_REG_STATUS: begin
            reg_rdata_o <= {mask_cnt_r, 3'h0, fifo_level, 3'h0, pend_r, busy_r, state_r};
          end
          `LSA_REG_HEIGHT: begin
            reg_rdata_o <= `LSA_HEIGHT;
          end
          default: begin
            reg_rdata_o <= 32'h00000000;
          end
        endcase
      end
    end
  end
endmodule

// File: lsa_line_scan_acq_sva.sv
`timescale 1ns/100ps
`include "lsa_consts.vh"
module lsa_acq_sva #(
  parameter PIX_W = 12,
  parameter [31:0] MIN_PERIOD_CYC = 20,
  parameter [31:0] MAX_PERIOD_CYC = 2000
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [7:0] reg_addr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_rdata_o,
  input wire line_req_o,
  input wire out_valid_o,
  input wire out_ready_i,
  input wire [3*PIX_W-1:0] out_data_o,
  input wire out_last_o
);
  // ----------------------------------------
  // Cycles since the last line request
  // ----------------------------------------
  reg [11:0] gap_r;
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      gap_r <= 12'hFFF;
    else if (line_req_o)
      gap_r <= 12'h000;
    else if (gap_r != 12'hFFF)
      gap_r <= gap_r + 12'h001;
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence rd_s(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  rd_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data not cleared");
  height_one_a: assert property (rd_s(`LSA_REG_HEIGHT) |=> reg_rdata_o == `LSA_HEIGHT)
    else $error("height not one");
  width_legal_a: assert property (rd_s(`LSA_REG_WIDTH) |=> reg_rdata_o[2:0] == 3'h0 &&
    reg_rdata_o[11:0] >= `LSA_WIDTH_MIN_BIN && reg_rdata_o[11:0] <= `LSA_WIDTH_RST)
    else $error("width illegal");
  depth_code_a: assert property (rd_s(`LSA_REG_CTRL) |=> reg_rdata_o[3:2] != 2'h3)
    else $error("depth code illegal");
  period_range_a: assert property (rd_s(`LSA_REG_PERIOD) |=> reg_rdata_o >= MIN_PERIOD_CYC
    && reg_rdata_o <= MAX_PERIOD_CYC) else $error("period out of range");
  out_hold_a: assert property (out_valid_o && !out_ready_i |=> out_valid_o &&
    $stable(out_data_o) && $stable(out_last_o)) else $error("stalled word changed");
  req_pulse_a: assert property (line_req_o |=> !line_req_o [*8])
    else $error("line request too long");
  line_gap_a: assert property (line_req_o |-> gap_r >= 12'd2000)
    else $error("line request during line");
endmodule

bind lsa_line_scan_acq lsa_acq_sva #(.PIX_W(PIX_W), .MIN_PERIOD_CYC(MIN_PERIOD_CYC),
  .MAX_PERIOD_CYC(MAX_PERIOD_CYC)) lsa_acq_sva_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .line_req_o(line_req_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
  .out_data_o(out_data_o), .out_last_o(out_last_o));

// File: lsa_grabber_model.sv
`timescale 1ns/100ps
module lsa_grabber_model (
  input wire clk_i,
  input wire slow_i,
  output reg out_ready_o
);
  // Slow mode takes one word in four so the stream FIFO fills and pushes back
  initial out_ready_o = 1'b0;
  always @(posedge clk_i) begin
    out_ready_o <= !slow_i || $urandom % 4 == 0;
  end
endmodule

// File: test_line_scan_acquisition_control.sv
`timescale 1ns/100ps
`include "lsa_consts.vh"
module test_line_scan_acquisition_control;
  reg clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg [7:0] reg_addr_i = 8'h00;
  reg [31:0] reg_wdata_i = 32'h0;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  reg ext_trigger_i = 1'b0;
  reg px_valid_i = 1'b0;
  reg [35:0] px_data_i = 36'h0;
  reg slow = 1'b0;
  wire [31:0] reg_rdata_o;
  wire line_req_o, px_ready_o, out_valid_o, out_ready_i, out_last_o;
  wire [35:0] out_data_o;
  integer n_mismatch = 0, samples_checked = 0, n_req = 0, idx = 2048, mask_left = 0;
  integer bin_m = 0, avg_m = 0, dep_m = 0, w_m = 0, o_m = 0, skip = 0, a_m = 0, v, k, i;
  reg [36:0] expq[$];
  reg [36:0] e;

  lsa_line_scan_acq #(.MIN_PERIOD_CYC(20), .MAX_PERIOD_CYC(2000)) lsa_line_scan_acq_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .ext_trigger_i(ext_trigger_i), .line_req_o(line_req_o),
    .px_valid_i(px_valid_i), .px_ready_o(px_ready_o), .px_data_i(px_data_i),
    .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_data_o(out_data_o),
    .out_last_o(out_last_o));
  lsa_grabber_model lsa_grabber_model_inst (.clk_i(clk_i), .slow_i(slow),
    .out_ready_o(out_ready_i));

  always #2 clk_i = ~clk_i;

  // ----------------------------------------
  // Sensor source, reference model, output compare
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (out_valid_o && out_ready_i) begin
      e = expq.size() ? expq.pop_front() : 37'bx;
      check({out_last_o, out_data_o}, e);
    end
    if (px_valid_i && px_ready_o) begin
      k = bin_m ? idx / 2 : idx;
      v = bin_m ? a_m + px_data_i[11:0] : px_data_i[11:0];
      if (bin_m)
        v = avg_m ? v / 2 : (v > 4095 ? 4095 : v);
      v = v >> (4 - 2 * dep_m);
      if (bin_m && idx % 2 == 0)
        a_m = px_data_i[11:0];
      else if (!skip && k >= o_m && k < o_m + w_m)
        expq.push_back({k == o_m + w_m - 1, 24'h0, v[11:0]});
      idx = idx + 1;
    end
    if (line_req_o) begin
      n_req = n_req + 1;
      idx = 0;
      skip = mask_left > 0;
      if (skip)
        mask_left = mask_left - 1;
    end
    // Idle data lines change every cycle so a stale value never matches by luck
    if (!px_valid_i || px_ready_o) begin
      px_valid_i <= idx < 2048 && $urandom % 8 != 0;
      px_data_i <= {4'($urandom), 32'($urandom)};
    end
  end

  task check(input [36:0] got, input [36:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
    end
  endtask

  task rd(input [7:0] a, input [31:0] x);
    begin
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 check({5'h0, reg_rdata_o}, {5'h0, x});
    end
  endtask

  task pulse;
    begin
      @(posedge clk_i);
      ext_trigger_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_trigger_i <= 1'b0;
    end
  endtask

  // Width drops to 128 first so every step stays legal in either binning mode
  task cfg(input integer c, input integer w, input integer o);
    begin
      wr(`LSA_REG_WIDTH, 128);
      wr(`LSA_REG_OFFSET, o);
      wr(`LSA_REG_CTRL, c);
      wr(`LSA_REG_WIDTH, w);
      rd(`LSA_REG_WIDTH, w);
      rd(`LSA_REG_OFFSET, o);
      bin_m = c & 1;
      avg_m = (c >> 1) & 1;
      dep_m = (c >> 2) & 3;
      w_m = w;
      o_m = o;
    end
  endtask

  // m: 0 internal pacing, 1 start trigger, 2 finish trigger, 3 per-line trigger
  task go(input integer n, input integer m, input integer mk);
    integer n0, c;
    begin
      n0 = n_req;
      c = 0;
      mask_left = mk;
      wr(`LSA_REG_CMD, 1);
      if (m == 0) begin
        while (n_req == n0) begin
          @(posedge clk_i);
          #1 c = c + 1;
        end
        check(c >= 19 && c <= 24, 1);
      end
      if (m == 1 || m == 3) begin
        repeat (300) @(posedge clk_i);
        check(n_req, n0);
      end
      if (m == 1)
        pulse;
      for (c = 0; c < n && m == 3; c = c + 1) begin
        pulse;
        repeat (3000) @(posedge clk_i);
      end
      if (m == 3)
        check(n_req, n0 + n);
      while (n_req < n0 + n) @(posedge clk_i);
      if (m == 2)
        pulse;
      else
        wr(`LSA_REG_CMD, 2);
      repeat (2) begin
        repeat (100) @(posedge clk_i);
        for (c = 0; c < 6000 && (idx < 2048 || expq.size() != 0); c = c + 1)
          @(posedge clk_i);
      end
      check(expq.size(), 0);
      n0 = n_req;
      pulse;
      repeat (300) @(posedge clk_i);
      check(n_req, n0);
    end
  endtask

  task conclude;
    begin
      $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  initial begin
    #380000;
    n_mismatch = n_mismatch + 1;
    conclude;
  end

  initial begin
    void'($urandom(74));
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(`LSA_REG_CTRL, 0);
    rd(`LSA_REG_WIDTH, 32'h800);
    rd(`LSA_REG_PERIOD, 20);
    rd(`LSA_REG_MASK, 0);
    rd(`LSA_REG_HEIGHT, 1);
    rd(`LSA_REG_STATUS, 1);
    rd(8'h24, 0);
    wr(`LSA_REG_OFFSET, 8);
    rd(`LSA_REG_OFFSET, 0);
    wr(`LSA_REG_WIDTH, 120);
    rd(`LSA_REG_WIDTH, 32'h800);
    wr(`LSA_REG_WIDTH, 132);
    rd(`LSA_REG_WIDTH, 32'h800);
    wr(`LSA_REG_PERIOD, 19);
    rd(`LSA_REG_PERIOD, 20);
    wr(`LSA_REG_PERIOD, 2001);
    rd(`LSA_REG_PERIOD, 20);
    wr(`LSA_REG_CTRL, 12);
    rd(`LSA_REG_CTRL, 0);
    for (i = 0; i < 5; i = i + 1) begin
      slow <= i % 2;
      cfg(i < 3 ? i * 4 : 9 + (i - 3) * 2, i < 3 ? 128 : 64, i < 3 ? 8 : 896);
      wr(`LSA_REG_MASK, i == 0 ? 2 : 0);
      go(i == 0 ? 3 : 1, 0, i == 0 ? 2 : 0);
    end
    slow <= 1'b0;
    wr(`LSA_REG_MASK, 1);
    cfg(25, 64, 896);
    go(2, 1, 1);
    // Halt while armed: back to idle, and later triggers start nothing
    wr(`LSA_REG_CMD, 1);
    rd(`LSA_REG_STATUS, 2);
    wr(`LSA_REG_CMD, 2);
    rd(`LSA_REG_STATUS, 1);
    i = n_req;
    pulse;
    repeat (300) @(posedge clk_i);
    check(n_req, i);
    wr(`LSA_REG_MASK, 3);
    cfg(57, 64, 896);
    go(1, 2, 0);
    cfg(89, 64, 896);
    go(3, 3, 0);
    conclude;
  end
endmodule
